// file: rfs_pkg.sv
// Purpose: shared constants for the remap fault status register block
// Assumes: 32-bit axi4-lite register space, one aligned word per register
// Notes:   offsets are byte addresses
package rfs_pkg;
    localparam logic [11:0] FSTS_OFFSET    = 12'h034;
    localparam logic [11:0] FECTL_OFFSET   = 12'h038;
    localparam logic [11:0] FSUPP_OFFSET   = 12'h03c; // feature readback
    localparam int          ADDR_W         = 12;
    localparam int          BIT_PFO        = 0;
    localparam int          BIT_PPF        = 1;
    localparam int          BIT_AFO        = 2;
    localparam int          BIT_APF        = 3;
    localparam int          BIT_IQE        = 4;
    localparam int          BIT_ICE        = 5;
    localparam int          BIT_ITE        = 6;
    localparam int          FRI_LSB        = 8;
    localparam int          FRI_W          = 8;
    localparam int          BIT_MASK       = 31;
    localparam int          BIT_PEND       = 30;
    localparam logic [31:0] FSTS_RESET     = 32'h0000_0000;
    localparam logic        MASK_RESET     = 1'b1;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage : rfs_pkg

// file: rfs_fault_status.sv
// Purpose: fault status register with event request and axi4-lite slave
// Assumes: fault inputs are synchronous to aclk; record flags are levels, the others one-cycle pulses
// Notes:   event control register kept here only for its mask and pending bits
// Notes on behaviour
// - status register sits at byte offset 034h
// - pointer meaningful only while primary pending set
// - pointer holds index of first pending record
// - bit 7 and bits 31:16 read zero
// - timeout sets bit 6, requests event
// - no device caches: bits 6,5 read zero
// - bad completion sets bit 5
// - queue fetch or descriptor error sets bit 4
// - no queued invalidation: bit 4 reads zero
// - first advanced record sets bit 3, event
// - advanced log overflow sets bit 2, event
// - write one clears bits 3,2; zero keeps
// - no advanced logging: bits 3,2 read zero
// - primary pending is OR of record flags
// - pending rise updates pointer and requests event
// - record overflow sets bit 0, write-one clears
// - overflow set blocks new fault recording
// - event message only while mask bit zero
`timescale 1ns/1ns
module rfs_fault_status
    import rfs_pkg::*;
#(
    parameter int NUM_REC     = 8,
    parameter bit HAS_DEVTLB  = 1'b1,
    parameter bit HAS_QINV    = 1'b1,
    parameter bit HAS_ADVLOG  = 1'b1
)
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [rfs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [rfs_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic [NUM_REC-1:0]       rec_fault,
    input  wire logic                     rec_overflow,
    input  wire logic                     adv_first_rec,
    input  wire logic                     adv_overflow,
    input  wire logic                     inval_queue_err,
    input  wire logic                     inval_compl_err,
    input  wire logic                     inval_timeout,
    output logic                          record_enable,
    output logic                          fault_msg
);
    import rfs_pkg::*;

    // elaboration guard: the pointer field indexes at most 256 records
    if (NUM_REC < 1 || NUM_REC > 256)
    begin : g_bad_num_rec
        $error("NUM_REC must be 1..256");
    end

    // status and control storage
    logic [7:0]         first_record_pointer_reg;
    logic               primary_pending_flag_reg;
    logic               primary_overflow_flag_reg;
    logic               advanced_pending_flag_reg;
    logic               advanced_overflow_flag_reg;
    logic               inval_queue_error_reg;
    logic               inval_completion_error_reg;
    logic               inval_timeout_error_reg;
    logic               event_mask_bit_reg;
    logic               event_pending_reg;
    logic [FRI_W-1:0]   first_idx;
    logic               any_fault;
    logic               ppf_rise;
    logic               ev_req;

    // axi write side
    logic               aw_have_reg;
    logic               w_have_reg;
    logic [ADDR_W-1:0]  awaddr_reg;
    logic [31:0]        wdata_reg;
    logic [3:0]         wstrb_reg;
    logic               wr_go;
    logic               wr_fsts;
    logic               wr_fectl;
    logic [31:0]        w1c;

    assign wr_go    = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_fsts  = wr_go && (awaddr_reg[ADDR_W-1:2] ==
                      FSTS_OFFSET[ADDR_W-1:2]);
    assign wr_fectl = wr_go && (awaddr_reg[ADDR_W-1:2] ==
                      FECTL_OFFSET[ADDR_W-1:2]);
    // only byte lane 0 holds writable status bits
    assign w1c      = (wr_fsts && wstrb_reg[0]) ? wdata_reg : 32'h0;

    // pick lowest flagged record as first pending index
    always_comb
    begin
        first_idx = '0;
        for (int i = NUM_REC - 1; i >= 0; i--)
            if (rec_fault[i])
                first_idx = FRI_W'(i);
    end
    assign any_fault = |rec_fault;
    assign ppf_rise  = any_fault && !primary_pending_flag_reg;

    // capture channels; each ready drops once its item is held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_have_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            else if (wr_go)
                w_have_reg <= 1'b0;
        end
    end

    // readies as registers so outputs come from flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready)
                             && !s_axi_bvalid;
            s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready)
                             && !s_axi_bvalid;
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_fsts || wr_fectl ||
                             awaddr_reg[ADDR_W-1:2] == FSUPP_OFFSET[ADDR_W-1:2])
                            ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // primary pending follows the record flags; pointer latched on rise
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            primary_pending_flag_reg <= FSTS_RESET[BIT_PPF];
            first_record_pointer_reg <= FSTS_RESET[FRI_LSB +: FRI_W];
        end
        else
        begin
            primary_pending_flag_reg <= any_fault;
            if (ppf_rise)
                first_record_pointer_reg <= first_idx;
        end
    end

    // sticky flags; set beats a same-cycle write-one clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            primary_overflow_flag_reg  <= FSTS_RESET[BIT_PFO];
            advanced_pending_flag_reg  <= FSTS_RESET[BIT_APF];
            advanced_overflow_flag_reg <= FSTS_RESET[BIT_AFO];
            inval_queue_error_reg      <= FSTS_RESET[BIT_IQE];
            inval_completion_error_reg <= FSTS_RESET[BIT_ICE];
            inval_timeout_error_reg    <= FSTS_RESET[BIT_ITE];
        end
        else
        begin
            primary_overflow_flag_reg <= rec_overflow ||
                (primary_overflow_flag_reg && !w1c[BIT_PFO]);
            advanced_pending_flag_reg <= HAS_ADVLOG && (adv_first_rec ||
                (advanced_pending_flag_reg && !w1c[BIT_APF]));
            advanced_overflow_flag_reg <= HAS_ADVLOG && (adv_overflow ||
                (advanced_overflow_flag_reg && !w1c[BIT_AFO]));
            inval_queue_error_reg <= HAS_QINV && (inval_queue_err ||
                (inval_queue_error_reg && !w1c[BIT_IQE]));
            inval_completion_error_reg <= HAS_DEVTLB && (inval_compl_err ||
                (inval_completion_error_reg && !w1c[BIT_ICE]));
            inval_timeout_error_reg <= HAS_DEVTLB && (inval_timeout ||
                (inval_timeout_error_reg && !w1c[BIT_ITE]));
        end
    end

    // recording gated off while primary overflow is held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            record_enable <= 1'b1;
        else
            record_enable <= !(rec_overflow ||
                (primary_overflow_flag_reg && !w1c[BIT_PFO]));
    end

    // new event: a flag rising from clear
    assign ev_req = ppf_rise
        || (rec_overflow && !primary_overflow_flag_reg)
        || (HAS_ADVLOG && adv_first_rec && !advanced_pending_flag_reg)
        || (HAS_ADVLOG && adv_overflow && !advanced_overflow_flag_reg)
        || (HAS_QINV && inval_queue_err && !inval_queue_error_reg)
        || (HAS_DEVTLB && inval_compl_err && !inval_completion_error_reg)
        || (HAS_DEVTLB && inval_timeout && !inval_timeout_error_reg);

    // mask resets set; a masked event waits as pending until unmasked
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            event_mask_bit_reg <= MASK_RESET;
            event_pending_reg  <= 1'b0;
            fault_msg          <= 1'b0;
        end
        else
        begin
            if (wr_fectl && wstrb_reg[3])
                event_mask_bit_reg <= wdata_reg[BIT_MASK];
            fault_msg         <= (ev_req || event_pending_reg) &&
                                 !event_mask_bit_reg;
            event_pending_reg <= (ev_req || event_pending_reg) &&
                                 event_mask_bit_reg;
        end
    end

    // read path; single cycle, held until rready
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0;
        if (s_axi_araddr[ADDR_W-1:2] == FSTS_OFFSET[ADDR_W-1:2])
        begin
            rd_val[FRI_LSB +: FRI_W] = first_record_pointer_reg;
            rd_val[BIT_PPF] = primary_pending_flag_reg;
            rd_val[BIT_PFO] = primary_overflow_flag_reg;
            rd_val[BIT_APF] = advanced_pending_flag_reg;
            rd_val[BIT_AFO] = advanced_overflow_flag_reg;
            rd_val[BIT_IQE] = inval_queue_error_reg;
            rd_val[BIT_ICE] = inval_completion_error_reg;
            rd_val[BIT_ITE] = inval_timeout_error_reg;
        end
        else if (s_axi_araddr[ADDR_W-1:2] == FECTL_OFFSET[ADDR_W-1:2])
        begin
            rd_val[BIT_MASK] = event_mask_bit_reg;
            rd_val[BIT_PEND] = event_pending_reg;
        end
        else if (s_axi_araddr[ADDR_W-1:2] == FSUPP_OFFSET[ADDR_W-1:2])
            rd_val[2:0] = {HAS_ADVLOG, HAS_QINV, HAS_DEVTLB};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <=
                    (s_axi_araddr[ADDR_W-1:2] == FSTS_OFFSET[ADDR_W-1:2] ||
                     s_axi_araddr[ADDR_W-1:2] == FECTL_OFFSET[ADDR_W-1:2] ||
                     s_axi_araddr[ADDR_W-1:2] == FSUPP_OFFSET[ADDR_W-1:2])
                    ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_PPF_OR: assert property (##1 primary_pending_flag_reg == $past(any_fault))
        else $error("primary pending not OR of record flags");
    AST_FRI_LATCH: assert property (ppf_rise |=> first_record_pointer_reg == $past(first_idx))
        else $error("pointer not latched on pending rise");
    AST_FRI_HOLD: assert property (primary_pending_flag_reg && any_fault |=> $stable(first_record_pointer_reg))
        else $error("pointer moved while pending held");
    AST_PFO_SET: assert property (rec_overflow |=> primary_overflow_flag_reg && !record_enable)
        else $error("overflow not set");
    AST_PFO_BLOCK: assert property (primary_overflow_flag_reg |-> !record_enable)
        else $error("recording while overflow set");
    AST_W1C_APF: assert property (advanced_pending_flag_reg && w1c[BIT_APF] && !adv_first_rec |=> !advanced_pending_flag_reg)
        else $error("advanced pending not cleared");
    AST_W0_KEEP: assert property (inval_timeout_error_reg && !w1c[BIT_ITE] |=> inval_timeout_error_reg)
        else $error("timeout flag lost");
    AST_RSVD: assert property (s_axi_rvalid |-> s_axi_rdata[29:16] == 14'h0 && (s_axi_rdata[7] == 1'b0))
        else $error("reserved bits read nonzero");
    AST_MASK: assert property (fault_msg |-> $past(!event_mask_bit_reg))
        else $error("message sent while masked");
    AST_MSG_LAT: assert property (ev_req && !event_mask_bit_reg |=> fault_msg)
        else $error("event not signalled in one cycle");
    AST_QE: assert property (inval_queue_err |=> inval_queue_error_reg == HAS_QINV)
        else $error("queue error not recorded");

    COV_PPF: cover property (ppf_rise ##1 fault_msg);
    COV_W1C: cover property (inval_completion_error_reg ##1 !inval_completion_error_reg);
    COV_UNMASK: cover property (event_pending_reg ##1 fault_msg);
    COV_OVF: cover property (rec_overflow ##[1:20] record_enable);
endmodule : rfs_fault_status

// file: remap_fault_status_reg_tb.sv
// Purpose: self-checking bench for the remap fault status register block
// Assumes: registered axi4-lite slave, every answer awaited under a bound
// Notes:   random record flags come from an lfsr seeded with 43149
`timescale 1ns/1ns
module remap_fault_status_reg_tb;
    import rfs_pkg::*;
    logic              aclk;
    logic              aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr;
    logic [ADDR_W-1:0] s_axi_araddr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [7:0]        rec_fault;
    logic              rec_overflow, adv_first_rec, adv_overflow;
    logic              inval_queue_err, inval_compl_err, inval_timeout;
    logic              record_enable, fault_msg;
    logic [15:0]       lfsr;
    int                errors, checks, msgs, m0;
    int                bits[6] = '{0, 2, 3, 4, 5, 6};
    logic [7:0]        vals[6];

    rfs_fault_status DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .rec_fault(rec_fault),
        .rec_overflow(rec_overflow), .adv_first_rec(adv_first_rec),
        .adv_overflow(adv_overflow), .inval_queue_err(inval_queue_err),
        .inval_compl_err(inval_compl_err), .inval_timeout(inval_timeout),
        .record_enable(record_enable), .fault_msg(fault_msg)
    );

    // free-running clock, 50 ns period
    initial aclk = 1'b0;
    always #25 aclk = ~aclk;

    // count event messages as they leave the block
    always @(posedge aclk) if (fault_msg === 1'b1) msgs++;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // lowest set index is taken as the first pending record
    function automatic logic [7:0] first_idx(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 7; i >= 0; i--) if (v[i]) r = 8'(i);
        return r;
    endfunction : first_idx

    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e,
                            input string what);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, what, g, e);
        end
    endtask : cmp_word

    task automatic stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    // write with address and data offered together, response compared
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] er);
        logic aw, w;
        int   n;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w && s_axi_bvalid === 1'b1) && n < 200)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready === 1'b1)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        cmp_word({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
        // let an edge pass so a next call never re-raises bready at once
        @(posedge aclk);
        if (n >= 200) errors++;
    endtask : wr_chk

    // read, then compare masked data and the response code
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                          input logic [31:0] m, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_rvalid !== 1'b1 && n < 200)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        cmp_word(s_axi_rdata & m, e, "rdata");
        cmp_word({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
        // let an edge pass so a next call never re-raises rready at once
        @(posedge aclk);
        if (n >= 200) errors++;
    endtask : rd_chk

    // one-cycle pulse on the source tied to status bit b
    task automatic pulse(input int b);
        case (b)
            0: rec_overflow <= 1'b1;
            2: adv_overflow <= 1'b1;
            3: adv_first_rec <= 1'b1;
            4: inval_queue_err <= 1'b1;
            5: inval_compl_err <= 1'b1;
            default: inval_timeout <= 1'b1;
        endcase
        @(posedge aclk);
        {rec_overflow, adv_overflow, adv_first_rec, inval_queue_err,
         inval_compl_err, inval_timeout} <= 6'h00;
    endtask : pulse

    // watchdog: the full sequence needs well under 4000 cycles
    initial
    begin
        #(50 * 20000);
        errors++;
        stop_test();
    end

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {rec_overflow, adv_overflow, adv_first_rec, inval_queue_err,
         inval_compl_err, inval_timeout} = 6'h00;
        rec_fault = 8'h00;
        aresetn = 1'b0;
        lfsr = 16'd43149;
        {errors, checks, msgs} = '0;
        tick(5);
        aresetn <= 1'b1;
        tick(2);
        rd_chk(FSTS_OFFSET, 32'h0, 32'hffff_ffff, RESP_OKAY);
        rd_chk(FECTL_OFFSET, 32'h8000_0000, 32'hffff_ffff, RESP_OKAY);
        cmp_word({31'h0, record_enable}, 32'h1, "record enable");
        $display("test reset done");
        // masked event waits, then leaves once the mask drops
        pulse(6);
        tick(2);
        rd_chk(FSTS_OFFSET, 32'h40, 32'hffff_ffff, RESP_OKAY);
        cmp_word(32'(msgs), 32'h0, "masked msg");
        wr_chk(FECTL_OFFSET, 32'h0, 4'h8, RESP_OKAY);
        tick(3);
        cmp_word(32'(msgs), 32'h1, "unmasked msg");
        wr_chk(FSTS_OFFSET, 32'h40, 4'h1, RESP_OKAY);
        $display("test mask done");
        // every sticky flag: set, event, zero write keeps, one write clears
        foreach (bits[i])
        begin
            m0 = msgs;
            pulse(bits[i]);
            tick(2);
            cmp_word(32'(msgs), 32'(m0 + 1), "flag msg");
            rd_chk(FSTS_OFFSET, 32'h1 << bits[i], 32'hffff_ffff, RESP_OKAY);
            if (bits[i] == 0)
                cmp_word({31'h0, record_enable}, 32'h0, "record hold");
            wr_chk(FSTS_OFFSET, 32'h0, 4'h1, RESP_OKAY);
            rd_chk(FSTS_OFFSET, 32'h1 << bits[i], 32'hffff_ffff, RESP_OKAY);
            wr_chk(FSTS_OFFSET, 32'hffff_ffff, 4'hf, RESP_OKAY);
            rd_chk(FSTS_OFFSET, 32'h0, 32'hffff_ffff, RESP_OKAY);
            tick(1);
            cmp_word({31'h0, record_enable}, 32'h1, "record free");
        end
        $display("test flags done");
        // record flags: corner indices then random patterns
        vals[0] = 8'h01;
        vals[1] = 8'h80;
        for (int i = 2; i < 6; i++)
        begin
            lfsr = lfsr_next(lfsr);
            vals[i] = (lfsr[7:0] == 8'h00) ? 8'h24 : lfsr[7:0];
        end
        foreach (vals[i])
        begin
            m0 = msgs;
            rec_fault <= vals[i];
            tick(3);
            rd_chk(FSTS_OFFSET, {16'h0, first_idx(vals[i]), 8'h02},
                   32'hffff_ffff, RESP_OKAY);
            cmp_word(32'(msgs), 32'(m0 + 1), "pending msg");
            wr_chk(FSTS_OFFSET, 32'hffff_ff80, 4'hf, RESP_OKAY);
            rd_chk(FSTS_OFFSET, {16'h0, first_idx(vals[i]), 8'h02},
                   32'hffff_ffff, RESP_OKAY);
            rec_fault <= 8'h00;
            tick(3);
            rd_chk(FSTS_OFFSET, 32'h0, 32'hffff_00ff, RESP_OKAY);
        end
        $display("test pending done");
        // unmapped place answers with an error and stores nothing
        wr_chk(12'h040, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        rd_chk(12'h040, 32'h0, 32'hffff_ffff, RESP_SLVERR);
        rd_chk(FSTS_OFFSET, 32'h0, 32'hffff_ffff, RESP_OKAY);
        $display("test unmapped done");
        stop_test();
    end
endmodule : remap_fault_status_reg_tb
